// ===== shared/src_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * system reset controller.
 * Assumes a single core clock whose rate is given here in kHz.
 */
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define SRC_CLK_KHZ 200000
`define SRC_SETTLE_MS 15
`define SRC_SETTLE_CYC (`SRC_SETTLE_MS * `SRC_CLK_KHZ)
`define SRC_BOR_HOLD_US 500
`define SRC_BOR_HOLD_CYC (`SRC_BOR_HOLD_US * (`SRC_CLK_KHZ / 1000))
`define SRC_INT_HOLD_CYC 32'h0000_0010

// ****************************************************************
// register offsets
// ****************************************************************
`define SRC_OFF_CAUSE 8'h00
`define SRC_OFF_BORCTL 8'h04
`define SRC_OFF_REGCTL 8'h08
`define SRC_OFF_SOFT0 8'h0c
`define SRC_OFF_SOFT1 8'h10
`define SRC_OFF_SOFT2 8'h14
`define SRC_OFF_WDLOAD 8'h18
`define SRC_OFF_WDCTL 8'h1c
`define SRC_OFF_WDSTAT 8'h20
`define SRC_OFF_WDCNT 8'h24

// ****************************************************************
// field positions
// ****************************************************************
`define SRC_CAUSE_EXT 0
`define SRC_CAUSE_POR 1
`define SRC_CAUSE_BOR 2
`define SRC_CAUSE_SW 3
`define SRC_CAUSE_WDT 4
`define SRC_CAUSE_REG 5
`define SRC_BOR_RECHECK 0
`define SRC_BOR_SELECT 1
`define SRC_BOR_IRQ 2
`define SRC_BOR_DLY_LSB 8
`define SRC_BOR_DLY_MSB 23
`define SRC_REG_ENABLE 0
`define SRC_REG_FLAG 1
`define SRC_WD_ENABLE 0
`define SRC_WD_RSTEN 1
`define SRC_WD_IRQ 0

// ****************************************************************
// reset values
// ****************************************************************
`define SRC_CAUSE_RST 6'h00
`define SRC_CTL_RST 32'h0000_0000
`define SRC_WDLOAD_RST 32'hffff_ffff

`endif

// ===== shared/src_pkg.sv
/*
 * Types of the system reset controller.
 * Assumes nothing of its surroundings.
 */
package src_pkg;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    SRC_RUN = 2'b00,
    SRC_HOLD = 2'b01,
    SRC_SETTLE = 2'b10,
    SRC_INT = 2'b11
  } src_state_e;

endpackage : src_pkg

// ===== verilog/src_system_reset_control.sv
/*
 * System reset controller: gathers six reset sources, stretches the
 * internal reset, records causes, and holds a watchdog and soft resets.
 * Assumes all inputs synchronous to CORE_CLK_I and RESET_I to be the
 * true power-up reset of this logic.
 */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "src_cfg.svh"

// Overview of operation
// - six sources: pin, power-on, brownout, software, watchdog, regulator
// - cause bits set per reset, kept across resets
// - pin reset clears all other cause bits
// - pin reset spares the test port controller
// - pin release starts oscillator settle count
// - power-up waits for pin and power-on, then settles
// - power-on detect honoured only at first power-up
// - power-on reset also resets test port controller
// - brownout reset disabled until software enables it
// - brownout resets with select or after recheck, interrupts only if neither set
// - recheck resamples brownout after delay, confirmed resets
// - brownout condition clears 500 us after set
// - three soft-reset registers; set then clear resets
// - soft reset hits all domains of unit
// - soft-reset bits match clock gating bit positions
// - system reset request resets whole system, then releases
// - watchdog interrupts first, may reset on second
// - first time-out reloads 32-bit counter, keeps counting
// - watchdog resets only if interrupt uncleared and enabled
// - regulator fault sets flag, resets; disabled after reset
// - pin/power-on settle slow; internal resets short
module src_system_reset_control #(
  parameter int UNIT_W = 32,
  parameter int SETTLE_CYC = `SRC_SETTLE_CYC,
  parameter int BOR_HOLD_CYC = `SRC_BOR_HOLD_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic EXT_RESET_N_I,
  input wire logic POR_DETECT_I,
  input wire logic BROWNOUT_DETECT_I,
  input wire logic REGULATOR_FAULT_I,
  input wire logic SYSTEM_RESET_REQUEST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic CORE_RESET_O,
  output logic [3*UNIT_W-1:0] PERIPH_RESET_O,
  output logic TAP_RESET_O,
  output logic BROWNOUT_IRQ_O,
  output logic WATCHDOG_IRQ_O
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  src_pkg::src_state_e state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic core_rst_q, tap_rst_q, por_seen_q;
  logic [5:0] reset_cause_reg_q;
  logic brownout_recheck_enable_q, brownout_reset_select_q;
  logic [15:0] brownout_recheck_delay_q;
  logic bor_irq_q, bor_cond_q, bor_pend_q;
  logic [31:0] bor_life_q;
  logic [15:0] bor_wait_q;
  logic regulator_enable_q;
  logic [UNIT_W-1:0] soft_q [3];
  logic [31:0] watchdog_reload_value_q, wd_cnt_q;
  logic wd_en_q, wd_rsten_q, wd_irq_q;
  logic [31:0] rdata_q;
  logic sys_clr, ext_act, por_act, hard_act;
  logic bor_rise, bor_rst_evt, bor_irq_evt, wd_zero;
  logic sw_evt, wd_evt, reg_evt, int_evt;

  function automatic logic wr_at(input logic [7:0] a, input logic w,
                                 input logic [7:0] off);
    wr_at = w && (a == off);
  endfunction : wr_at

  // ****************************************************************
  // source detection
  // ****************************************************************
  assign sys_clr = RESET_I | core_rst_q;
  assign ext_act = !EXT_RESET_N_I;
  assign por_act = POR_DETECT_I && !por_seen_q;
  assign hard_act = ext_act | por_act;
  assign sw_evt = SYSTEM_RESET_REQUEST_I && state_q == src_pkg::SRC_RUN;
  assign reg_evt = REGULATOR_FAULT_I && regulator_enable_q;
  assign wd_zero = wd_en_q && wd_cnt_q == 32'h0000_0000;
  assign wd_evt = wd_zero && wd_irq_q && wd_rsten_q;
  assign bor_rise = BROWNOUT_DETECT_I && !bor_cond_q;
  assign bor_irq_evt = bor_rise && !brownout_reset_select_q
                       && !brownout_recheck_enable_q;
  assign bor_rst_evt = (bor_rise && brownout_reset_select_q)
                       || (bor_pend_q && bor_wait_q == 16'h0000
                           && BROWNOUT_DETECT_I);
  assign int_evt = sw_evt | wd_evt | reg_evt | bor_rst_evt;

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      src_pkg::SRC_HOLD: begin
        if (!hard_act) begin
          state_d = src_pkg::SRC_SETTLE;
          cnt_d = 32'(SETTLE_CYC - 1);
        end
      end
      src_pkg::SRC_SETTLE, src_pkg::SRC_INT: begin
        if (hard_act) begin
          state_d = src_pkg::SRC_HOLD;
        end else if (cnt_q == 32'h0000_0000) begin
          state_d = src_pkg::SRC_RUN;
        end else begin
          cnt_d = cnt_q - 32'h0000_0001;
        end
      end
      src_pkg::SRC_RUN: begin
        if (hard_act) begin
          state_d = src_pkg::SRC_HOLD;
        end else if (int_evt) begin
          state_d = src_pkg::SRC_INT;
          cnt_d = `SRC_INT_HOLD_CYC - 32'h0000_0001;
        end
      end
      default: begin
        state_d = src_pkg::SRC_HOLD;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      state_q <= src_pkg::SRC_HOLD;
      cnt_q <= 32'h0000_0000;
      core_rst_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      core_rst_q <= (state_d != src_pkg::SRC_RUN);
    end
  end

  // test port reset follows power-on only
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      tap_rst_q <= 1'b1;
      por_seen_q <= 1'b0;
    end else begin
      tap_rst_q <= por_act;
      if (state_q == src_pkg::SRC_SETTLE) begin
        por_seen_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // cause register
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      reset_cause_reg_q <= `SRC_CAUSE_RST;
    end else if (ext_act) begin
      reset_cause_reg_q <= 6'h01 << `SRC_CAUSE_EXT;
    end else begin
      reset_cause_reg_q <= (reset_cause_reg_q
        & ~(wr_at(ADDR_I, WR_I, `SRC_OFF_CAUSE) ? WDATA_I[5:0] : 6'h00))
        | ({5'h00, por_act} << `SRC_CAUSE_POR)
        | ({5'h00, bor_rst_evt} << `SRC_CAUSE_BOR)
        | ({5'h00, sw_evt} << `SRC_CAUSE_SW)
        | ({5'h00, wd_evt} << `SRC_CAUSE_WDT)
        | ({5'h00, reg_evt} << `SRC_CAUSE_REG);
    end
  end

  // ****************************************************************
  // brownout control and condition
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (sys_clr) begin
      brownout_recheck_enable_q <= 1'b0;
      brownout_reset_select_q <= 1'b0;
      brownout_recheck_delay_q <= 16'h0000;
      regulator_enable_q <= 1'b0;
    end else begin
      if (wr_at(ADDR_I, WR_I, `SRC_OFF_BORCTL)) begin
        brownout_recheck_enable_q <= WDATA_I[`SRC_BOR_RECHECK];
        brownout_reset_select_q <= WDATA_I[`SRC_BOR_SELECT];
        brownout_recheck_delay_q <= WDATA_I[`SRC_BOR_DLY_MSB:`SRC_BOR_DLY_LSB];
      end
      if (wr_at(ADDR_I, WR_I, `SRC_OFF_REGCTL)) begin
        regulator_enable_q <= WDATA_I[`SRC_REG_ENABLE];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      bor_irq_q <= 1'b0;
    end else if (bor_irq_evt) begin
      bor_irq_q <= 1'b1;
    end else if (wr_at(ADDR_I, WR_I, `SRC_OFF_BORCTL) && WDATA_I[`SRC_BOR_IRQ]) begin
      bor_irq_q <= 1'b0;
    end
  end

  // condition holds off new events for a fixed time
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      bor_cond_q <= 1'b0;
      bor_life_q <= 32'h0000_0000;
    end else if (bor_rise) begin
      bor_cond_q <= 1'b1;
      bor_life_q <= 32'(BOR_HOLD_CYC - 1);
    end else if (bor_cond_q) begin
      if (bor_life_q == 32'h0000_0000) begin
        bor_cond_q <= 1'b0;
      end else begin
        bor_life_q <= bor_life_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      bor_pend_q <= 1'b0;
      bor_wait_q <= 16'h0000;
    end else if (bor_rise && !brownout_reset_select_q && brownout_recheck_enable_q) begin
      bor_pend_q <= 1'b1;
      bor_wait_q <= brownout_recheck_delay_q;
    end else if (bor_pend_q) begin
      if (bor_wait_q == 16'h0000) begin
        bor_pend_q <= 1'b0;
      end else begin
        bor_wait_q <= bor_wait_q - 16'h0001;
      end
    end
  end

  // ****************************************************************
  // peripheral soft resets
  // ****************************************************************
  // bit k of each register is the unit at bit k of clock gating
  always_ff @(posedge CORE_CLK_I) begin
    if (sys_clr) begin
      soft_q[0] <= '0;
      soft_q[1] <= '0;
      soft_q[2] <= '0;
    end else begin
      if (wr_at(ADDR_I, WR_I, `SRC_OFF_SOFT0)) begin
        soft_q[0] <= WDATA_I[UNIT_W-1:0];
      end
      if (wr_at(ADDR_I, WR_I, `SRC_OFF_SOFT1)) begin
        soft_q[1] <= WDATA_I[UNIT_W-1:0];
      end
      if (wr_at(ADDR_I, WR_I, `SRC_OFF_SOFT2)) begin
        soft_q[2] <= WDATA_I[UNIT_W-1:0];
      end
    end
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (sys_clr) begin
      watchdog_reload_value_q <= `SRC_WDLOAD_RST;
      wd_cnt_q <= `SRC_WDLOAD_RST;
      wd_en_q <= 1'b0;
      wd_rsten_q <= 1'b0;
    end else begin
      if (wr_at(ADDR_I, WR_I, `SRC_OFF_WDLOAD)) begin
        watchdog_reload_value_q <= WDATA_I;
        wd_cnt_q <= WDATA_I;
      end else if (wd_zero) begin
        wd_cnt_q <= watchdog_reload_value_q;
      end else if (wd_en_q) begin
        wd_cnt_q <= wd_cnt_q - 32'h0000_0001;
      end
      if (wr_at(ADDR_I, WR_I, `SRC_OFF_WDCTL)) begin
        wd_en_q <= WDATA_I[`SRC_WD_ENABLE];
        wd_rsten_q <= WDATA_I[`SRC_WD_RSTEN];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (sys_clr) begin
      wd_irq_q <= 1'b0;
    end else if (wd_zero) begin
      wd_irq_q <= 1'b1;
    end else if (wr_at(ADDR_I, WR_I, `SRC_OFF_WDSTAT) && WDATA_I[`SRC_WD_IRQ]) begin
      wd_irq_q <= 1'b0;
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (RD_I) begin
      case (ADDR_I)
        `SRC_OFF_CAUSE: rdata_q <= {26'h0000000, reset_cause_reg_q};
        `SRC_OFF_BORCTL: rdata_q <= {8'h00, brownout_recheck_delay_q, 5'h00,
                                     bor_irq_q, brownout_reset_select_q,
                                     brownout_recheck_enable_q};
        `SRC_OFF_REGCTL: rdata_q <= {30'h00000000,
                                     reset_cause_reg_q[`SRC_CAUSE_REG],
                                     regulator_enable_q};
        `SRC_OFF_SOFT0: rdata_q <= 32'(soft_q[0]);
        `SRC_OFF_SOFT1: rdata_q <= 32'(soft_q[1]);
        `SRC_OFF_SOFT2: rdata_q <= 32'(soft_q[2]);
        `SRC_OFF_WDLOAD: rdata_q <= watchdog_reload_value_q;
        `SRC_OFF_WDCTL: rdata_q <= {30'h00000000, wd_rsten_q, wd_en_q};
        `SRC_OFF_WDSTAT: rdata_q <= {31'h00000000, wd_irq_q};
        `SRC_OFF_WDCNT: rdata_q <= wd_cnt_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign RDATA_O = rdata_q;
  assign CORE_RESET_O = core_rst_q;
  assign PERIPH_RESET_O = {soft_q[2], soft_q[1], soft_q[0]}
                          | {(3*UNIT_W){core_rst_q}};
  assign TAP_RESET_O = tap_rst_q;
  assign BROWNOUT_IRQ_O = bor_irq_q;
  assign WATCHDOG_IRQ_O = wd_irq_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_pin_release;
    !ext_act && !por_act && state_q == src_pkg::SRC_HOLD;
  endsequence
  sequence s_settling;
    state_q == src_pkg::SRC_SETTLE && core_rst_q;
  endsequence

  property p_pin_settle;
    s_pin_release |=> s_settling;
  endproperty
  a_pin_settle: assert property (p_pin_settle) else $error("no settle");

  property p_pin_cause;
    ext_act |=> reset_cause_reg_q == 6'h01 && core_rst_q;
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin cause");

  property p_sticky;
    !$past(ext_act) && !$past(WR_I) |->
      (reset_cause_reg_q & $past(reset_cause_reg_q)) == $past(reset_cause_reg_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("cause lost");

  property p_tap_spared;
    ext_act && !por_act |=> !tap_rst_q;
  endproperty
  a_tap_spared: assert property (p_tap_spared) else $error("tap hit");

  property p_por_once;
    por_seen_q |-> !por_act ##1 !tap_rst_q;
  endproperty
  a_por_once: assert property (p_por_once) else $error("por again");

  property p_bor_irq;
    bor_irq_evt && state_q == src_pkg::SRC_RUN && !hard_act && !int_evt |=>
      bor_irq_q && !core_rst_q;
  endproperty
  a_bor_irq: assert property (p_bor_irq) else $error("bor irq");

  property p_bor_hold;
    bor_rise |=> bor_cond_q [*2];
  endproperty
  a_bor_hold: assert property (p_bor_hold) else $error("bor cond");

  property p_wd_first;
    wd_zero && !wd_irq_q && !WR_I && !core_rst_q |=>
      wd_irq_q && wd_cnt_q == $past(watchdog_reload_value_q);
  endproperty
  a_wd_first: assert property (p_wd_first) else $error("wd reload");

  property p_wd_reset;
    wd_evt && !hard_act |=> core_rst_q [*8];
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("wd reset");

  property p_soft_reset;
    soft_q[0][0] |-> PERIPH_RESET_O[0];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset");

  property p_reg_fault;
    reg_evt && !ext_act |=> reset_cause_reg_q[`SRC_CAUSE_REG] ##1 core_rst_q;
  endproperty
  a_reg_fault: assert property (p_reg_fault) else $error("reg fault");

  property p_same_edge;
    core_rst_q |-> &PERIPH_RESET_O;
  endproperty
  a_same_edge: assert property (p_same_edge) else $error("split release");

endmodule : src_system_reset_control
`default_nettype wire

// ===== test/src_system_reset_control_tb.sv
/*
 * Self-checking bench for the system reset controller.
 * Assumes the design in verilog/ and src_cfg.svh on the include path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "src_cfg.svh"

module src_system_reset_control_tb;
  // ****************************************************************
  // stimulus signals and counters
  // ****************************************************************
  localparam int SETTLE = 20;
  localparam int HOLD = 50;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wd;
    logic [31:0] ex;
  } src_row_s;
  logic clk, rst, ext_n, por, bod, regf, sreq, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic core_rst, tap_rst, bor_irq, wd_irq;
  logic [95:0] periph;
  int errors, n_compared, cyc, n;
  src_row_s rows [8];

  src_system_reset_control #(.UNIT_W(32), .SETTLE_CYC(SETTLE), .BOR_HOLD_CYC(HOLD)) uut (
    .CORE_CLK_I(clk), .RESET_I(rst), .EXT_RESET_N_I(ext_n), .POR_DETECT_I(por),
    .BROWNOUT_DETECT_I(bod), .REGULATOR_FAULT_I(regf), .SYSTEM_RESET_REQUEST_I(sreq),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .CORE_RESET_O(core_rst), .PERIPH_RESET_O(periph), .TAP_RESET_O(tap_rst),
    .BROWNOUT_IRQ_O(bor_irq), .WATCHDOG_IRQ_O(wd_irq)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  // waits for the core reset to reach a level; n counts the cycles spent
  task automatic wait_core(input logic v, input int lim);
    n = 0;
    while (core_rst !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(core_rst, v);
  endtask : wait_core

  task automatic cause_is(input logic [31:0] exp);
    rd_reg(`SRC_OFF_CAUSE, d);
    chk(d, exp);
    wr_reg(`SRC_OFF_CAUSE, 32'h0000_003f);
  endtask : cause_is

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1; ext_n = 1'b1; por = 1'b1; bod = 1'b0; regf = 1'b0; sreq = 1'b0;
    wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0; errors = 0; n_compared = 0; cyc = 0;
    rows[0] = '{8'h0c, 32'ha5a5_a5a5, 32'ha5a5_a5a5};
    rows[1] = '{8'h10, 32'h0000_00ff, 32'h0000_00ff};
    rows[2] = '{8'h14, 32'h8000_0001, 32'h8000_0001};
    rows[3] = '{8'h04, 32'h0012_3407, 32'h0012_3403};
    rows[4] = '{8'h08, 32'h0000_0003, 32'h0000_0001};
    rows[5] = '{8'h18, 32'h0000_0100, 32'h0000_0100};
    rows[6] = '{8'h1c, 32'h0000_0000, 32'h0000_0000};
    rows[7] = '{8'h30, 32'hffff_ffff, 32'h0000_0000};
    tick(3);
    chk({core_rst, tap_rst, bor_irq, wd_irq}, 4'b1100);
    chk(periph, {96{1'b1}});
    @(posedge clk) rst <= 1'b0;
    tick(5);
    chk({core_rst, tap_rst}, 2'b11);
    @(posedge clk) por <= 1'b0;
    tick(1);
    wait_core(1'b0, 100);
    chk(n >= SETTLE, 1'b1);
    chk(periph, 96'h0);
    chk(tap_rst, 1'b0);
    cause_is(32'h0000_0002);
    $display("power-up test done");

    foreach (rows[i]) begin
      wr_reg(rows[i].addr, rows[i].wd);
      rd_reg(rows[i].addr, d);
      chk(d, rows[i].ex);
    end
    chk(periph, {32'h8000_0001, 32'h0000_00ff, 32'ha5a5_a5a5});
    wr_reg(`SRC_OFF_SOFT0, 32'h0);
    wr_reg(`SRC_OFF_SOFT1, 32'h0);
    wr_reg(`SRC_OFF_SOFT2, 32'h0);
    wr_reg(`SRC_OFF_BORCTL, 32'h0);
    wr_reg(`SRC_OFF_REGCTL, 32'h0);
    tick(1);
    chk(periph, 96'h0);
    $display("register table test done");

    // pin reset: cause set, others cleared, test port spared
    @(posedge clk) por <= 1'b1;
    tick(1);
    @(posedge clk) por <= 1'b0;
    wr_reg(`SRC_OFF_SOFT0, 32'h0000_0001);
    @(posedge clk) ext_n <= 1'b0;
    tick(3);
    chk({core_rst, tap_rst}, 2'b10);
    @(posedge clk) ext_n <= 1'b1;
    tick(1);
    wait_core(1'b0, 100);
    chk(n >= SETTLE, 1'b1);
    chk(tap_rst, 1'b0);
    rd_reg(`SRC_OFF_SOFT0, d);
    chk(d, 32'h0);
    @(posedge clk) sreq <= 1'b1;
    @(posedge clk) sreq <= 1'b0;
    tick(2);
    chk(core_rst, 1'b1);
    wait_core(1'b0, 40);
    chk(n >= 12, 1'b1);
    cause_is(32'h0000_0009);
    cause_is(32'h0000_0000);
    $display("pin and software reset test done");

    // brownout: interrupt when disabled, reset when selected
    @(posedge clk) bod <= 1'b1;
    tick(3);
    chk({bor_irq, core_rst}, 2'b10);
    wr_reg(`SRC_OFF_BORCTL, 32'h0000_0004);
    tick(1);
    chk(bor_irq, 1'b0);
    @(posedge clk) bod <= 1'b0;
    wr_reg(`SRC_OFF_BORCTL, 32'h0000_0002);
    @(posedge clk) bod <= 1'b1;
    tick(3);
    chk(core_rst, 1'b0);
    @(posedge clk) bod <= 1'b0;
    tick(HOLD);
    @(posedge clk) bod <= 1'b1;
    tick(3);
    chk(core_rst, 1'b1);
    @(posedge clk) bod <= 1'b0;
    wait_core(1'b0, 40);
    cause_is(32'h0000_0004);
    tick(HOLD);
    wr_reg(`SRC_OFF_BORCTL, 32'h0000_0401);
    @(posedge clk) bod <= 1'b1;
    @(posedge clk) bod <= 1'b0;
    tick(12);
    chk({core_rst, bor_irq}, 2'b00);
    tick(HOLD);
    @(posedge clk) bod <= 1'b1;
    tick(4);
    chk(core_rst, 1'b0);
    wait_core(1'b1, 10);
    @(posedge clk) bod <= 1'b0;
    wait_core(1'b0, 40);
    cause_is(32'h0000_0004);
    $display("brownout test done");

    // watchdog: interrupt first, reset on second time-out
    tick(HOLD);
    wr_reg(`SRC_OFF_WDLOAD, 32'h0000_000a);
    wr_reg(`SRC_OFF_WDCTL, 32'h0000_0003);
    wait_core(1'b0, 1);
    n = 0;
    while (wd_irq !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk({wd_irq, core_rst}, 2'b10);
    chk(n >= 8, 1'b1);
    wait_core(1'b1, 20);
    chk(n >= 8, 1'b1);
    wait_core(1'b0, 40);
    cause_is(32'h0000_0010);
    $display("watchdog test done");

    // regulator fault: ignored until enabled
    @(posedge clk) regf <= 1'b1;
    tick(5);
    chk(core_rst, 1'b0);
    @(posedge clk) regf <= 1'b0;
    wr_reg(`SRC_OFF_REGCTL, 32'h0000_0001);
    @(posedge clk) regf <= 1'b1;
    tick(3);
    chk(core_rst, 1'b1);
    @(posedge clk) regf <= 1'b0;
    wait_core(1'b0, 40);
    rd_reg(`SRC_OFF_REGCTL, d);
    chk(d, 32'h0000_0002);
    cause_is(32'h0000_0020);
    $display("regulator test done");
    complete_run();
  end
endmodule : src_system_reset_control_tb

`default_nettype wire
